// ===== hdl/mxc_external_move_ctrl.sv
// external move address forming, target steering and port claim control
// assumes the core issues one move request at a time and waits for done
`default_nettype none
// Summary of operation
// - program store control bits 7..3 read zero, writes ignored
// - scratchpad bit steers software flash access to the 128-byte sector
// - erase and write enable set: a move write erases the addressed page
// - erase of the page holding the lock bytes is refused
// - write enable set: move writes program flash, else go to data RAM or off-chip as the mode bits select
// - by default moves address the 4 kB on-chip data RAM
// - 8-bit form: page select gives high byte, R0/low byte
// - 16-bit form uses the whole data pointer
// - data pointer readable and writable as high and low bytes
// - interface sits on ports 0..3 or 4..7 by port select bit
// - pins are claimed only during an off-chip move
// - drivers of input pins are off during an off-chip move
// - pin output mode is never changed by the interface
// - page select NN picks the page 0xNN00..0xNNFF
// - port select 0 means ports 0..3, 1 means ports 4..7
// - flash writes and erases blocked unless the flash enable bit is set
module mxc_move_ctrl
    import mxc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic        flash_write_erase_enable,
    input  wire logic        move_req,
    input  wire mxc_req_type move,
    output logic             move_done,
    output logic [7:0]       move_rdata,
    output logic             ram_en,
    output logic             ram_we,
    output logic [11:0]      ram_addr,
    output logic [7:0]       ram_wdata,
    input  wire logic [7:0]  ram_rdata,
    output logic             flash_wr,
    output logic             flash_erase,
    output logic             flash_refused,
    output logic [15:0]      flash_addr,
    output logic [7:0]       flash_wdata,
    output logic             flash_scratch_sel,
    output mxc_pins_type     pins_lo,
    output mxc_pins_type     pins_hi,
    input  wire logic [7:0]  data_in_lo,
    input  wire logic [7:0]  data_in_hi
);
    logic [7:0]    program_store_control;
    logic [7:0]    data_page_select;
    logic [7:0]    interface_configuration;
    logic [15:0]   data_pointer;
    mxc_state_type state;
    mxc_tgt_type   tgt;
    mxc_tgt_type   next_tgt;
    logic [15:0]   next_ea;
    logic [15:0]   ea;
    logic [7:0]    wdata;
    logic          wr;
    logic          portsel;
    logic [2:0]    cnt;
    logic          last;
    logic          offchip;
    logic [7:0]    pin_rd;

    // ==========================================================
    // special register writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            program_store_control   <= MXC_PSC_RST;
            data_page_select        <= MXC_DPS_RST;
            interface_configuration <= MXC_CFG_RST;
            data_pointer            <= MXC_DP_RST;
        end
        else if (sfr_wr)
        begin
            if (sfr_addr == MXC_PSC_ADDR)
                program_store_control <= sfr_wdata & MXC_PSC_MASK;
            else if (sfr_addr == MXC_DPS_ADDR)
                data_page_select <= sfr_wdata;
            else if (sfr_addr == MXC_CFG_ADDR)
                interface_configuration <= sfr_wdata & MXC_CFG_MASK;
            else if (sfr_addr == MXC_PTRH_ADDR)
                data_pointer[15:8] <= sfr_wdata;
            else if (sfr_addr == MXC_PTRL_ADDR)
                data_pointer[7:0] <= sfr_wdata;
        end
    end

    // ==========================================================
    // registered read port, unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
        begin
            if (sfr_addr == MXC_PSC_ADDR)
                sfr_rdata <= program_store_control & MXC_PSC_MASK;
            else if (sfr_addr == MXC_DPS_ADDR)
                sfr_rdata <= data_page_select;
            else if (sfr_addr == MXC_CFG_ADDR)
                sfr_rdata <= interface_configuration;
            else if (sfr_addr == MXC_PTRH_ADDR)
                sfr_rdata <= data_pointer[15:8];
            else if (sfr_addr == MXC_PTRL_ADDR)
                sfr_rdata <= data_pointer[7:0];
            else
                sfr_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // effective address and target of a new request
    always_comb
    begin
        logic [1:0] mode;
        mode = interface_configuration[MXC_MODE_LSB +: 2];
        if (move.use_pointer)
            next_ea = data_pointer;
        else
            next_ea = {data_page_select, move.ri};
        if (mode == MXC_MODE_EXT)
            offchip = 1'b1;
        else if (mode == MXC_MODE_INT)
            offchip = 1'b0;
        else
            offchip = (next_ea >= MXC_ONCHIP_TOP);
        if (move.wr && program_store_control[MXC_WRITE_BIT])
        begin
            if (!flash_write_erase_enable)
                next_tgt = TGT_REFUSED;
            else if (!program_store_control[MXC_ERASE_BIT])
                next_tgt = TGT_FLASH_WR;
            else if (next_ea[15:9] == MXC_LOCK_PAGE)
                next_tgt = TGT_REFUSED;
            else
                next_tgt = TGT_ERASE;
        end
        else if (offchip)
            next_tgt = TGT_OFF;
        else
            next_tgt = TGT_RAM;
    end

    // ==========================================================
    // request latch: settings act from the next request onward
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgt     <= TGT_RAM;
            ea      <= 16'h0000;
            wdata   <= 8'h00;
            wr      <= 1'b0;
            portsel <= 1'b0;
        end
        else if (state == ST_IDLE && move_req)
        begin
            tgt     <= next_tgt;
            ea      <= next_ea;
            wdata   <= move.wdata;
            wr      <= move.wr;
            portsel <= interface_configuration[MXC_PORTSEL_BIT];
        end
    end

    // ==========================================================
    // sequencer
    assign last = (tgt != TGT_OFF) || (cnt == MXC_OFF_CYCLES - 3'h1);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            cnt   <= 3'h0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    cnt <= 3'h0;
                    if (move_req)
                        state <= ST_RUN;
                end
                ST_RUN:
                begin
                    cnt <= cnt + 3'h1;
                    if (last)
                        state <= ST_DONE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // one-cycle strobes toward on-chip RAM and flash
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ram_en        <= 1'b0;
            ram_we        <= 1'b0;
            ram_addr      <= 12'h000;
            ram_wdata     <= 8'h00;
            flash_wr      <= 1'b0;
            flash_erase   <= 1'b0;
            flash_refused <= 1'b0;
            flash_addr    <= 16'h0000;
            flash_wdata   <= 8'h00;
        end
        else
        begin
            ram_en        <= state == ST_IDLE && move_req && next_tgt == TGT_RAM;
            ram_we        <= move.wr;
            ram_addr      <= next_ea[11:0];
            ram_wdata     <= move.wdata;
            flash_wr      <= state == ST_IDLE && move_req && next_tgt == TGT_FLASH_WR;
            flash_erase   <= state == ST_IDLE && move_req && next_tgt == TGT_ERASE;
            flash_refused <= state == ST_IDLE && move_req && next_tgt == TGT_REFUSED;
            flash_addr    <= next_ea;
            flash_wdata   <= move.wdata;
        end
    end

    // scratchpad steering follows the control bit
    assign flash_scratch_sel = program_store_control[MXC_SCRATCH_BIT];

    // ==========================================================
    // completion and read data back to the core
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            move_done  <= 1'b0;
            move_rdata <= 8'h00;
        end
        else
        begin
            move_done <= state == ST_RUN && last;
            if (state == ST_RUN && last && !wr)
                move_rdata <= (tgt == TGT_OFF) ? pin_rd : ram_rdata;
        end
    end

    // ==========================================================
    // pin claim only while an off-chip move runs; output mode untouched
    mxc_pin_steer u_pins (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .active     (state == ST_RUN && tgt == TGT_OFF),
        .strobe     (cnt != 3'h0),
        .wr         (wr),
        .portsel    (portsel),
        .addr       (ea),
        .wdata      (wdata),
        .data_in_lo (data_in_lo),
        .data_in_hi (data_in_hi),
        .pins_lo    (pins_lo),
        .pins_hi    (pins_hi),
        .rd_data    (pin_rd)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_psc_upper_zero: assert property (program_store_control[7:3] == 5'h00)
        else $error("upper control bits not zero");
    a_ram_default: assert property (state == ST_IDLE && move_req && !move.wr
        && interface_configuration[3:2] == MXC_MODE_INT |=> ram_en)
        else $error("read did not reach on-chip RAM");
    a_page_addr: assert property (state == ST_IDLE && move_req && !move.use_pointer
        |=> ea == {$past(data_page_select), $past(move.ri)})
        else $error("8-bit address wrong");
    a_pointer_addr: assert property (state == ST_IDLE && move_req && move.use_pointer
        |=> ea == $past(data_pointer))
        else $error("16-bit address wrong");
    a_lock_erase: assert property (flash_erase |-> flash_addr[15:9] != MXC_LOCK_PAGE)
        else $error("lock page erased");
    a_enable_block: assert property (state == ST_IDLE && move_req && move.wr
        && !flash_write_erase_enable |=> !flash_wr && !flash_erase)
        else $error("flash change while disabled");
    a_erase_steer: assert property (state == ST_IDLE && move_req && move.wr && flash_write_erase_enable
        && program_store_control[1:0] == 2'h3 && next_ea[15:9] != MXC_LOCK_PAGE |=> flash_erase)
        else $error("page erase missing");
    a_claim_only: assert property (pins_lo.claim || pins_hi.claim |-> $past(state == ST_RUN && tgt == TGT_OFF))
        else $error("pins claimed outside off-chip move");
    a_read_no_drive: assert property ((pins_lo.claim && !pins_lo.wr_n) || !pins_lo.data_oe
        || $past(wr))
        else $error("data driven during read");
    a_off_done: assert property (state == ST_IDLE && move_req && next_tgt == TGT_OFF
        |-> ##5 move_done)
        else $error("off-chip move length wrong");
    c_offchip_read: cover property (pins_hi.claim && !pins_hi.rd_n);
    c_flash_erase: cover property (flash_erase);
    c_refused: cover property (flash_refused);
endmodule
`default_nettype wire

// ===== hdl/mxc_pkg.sv
// package for the external move target and port claim block
// assumes one 50 MHz clock and an 8-bit special register bus from the core
`default_nettype none
package mxc_pkg;
    // ==========================================================
    // register addresses on the special register bus
    localparam logic [7:0] MXC_PSC_ADDR = 8'h8f;
    localparam logic [7:0] MXC_DPS_ADDR = 8'ha2;
    localparam logic [7:0] MXC_CFG_ADDR = 8'ha3;
    localparam logic [7:0] MXC_PTRL_ADDR = 8'h82;
    localparam logic [7:0] MXC_PTRH_ADDR = 8'h83;
    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0]  MXC_PSC_RST  = 8'h00;
    localparam logic [7:0]  MXC_DPS_RST  = 8'h00;
    localparam logic [7:0]  MXC_CFG_RST  = 8'h03;
    localparam logic [15:0] MXC_DP_RST   = 16'h0000;
    localparam logic [7:0]  MXC_PSC_MASK = 8'h07;
    localparam logic [7:0]  MXC_CFG_MASK = 8'h3f;
    // ==========================================================
    // field positions
    localparam int MXC_SCRATCH_BIT = 2;
    localparam int MXC_ERASE_BIT   = 1;
    localparam int MXC_WRITE_BIT   = 0;
    localparam int MXC_PORTSEL_BIT = 5;
    localparam int MXC_MODE_LSB    = 2;
    // ==========================================================
    // address space and timing
    localparam logic [15:0] MXC_ONCHIP_TOP = 16'h1000;
    localparam logic [6:0]  MXC_LOCK_PAGE  = 7'h7f;
    localparam logic [1:0]  MXC_MODE_INT   = 2'h0;
    localparam logic [1:0]  MXC_MODE_EXT   = 2'h3;
    localparam logic [2:0]  MXC_OFF_CYCLES = 3'h4;
    // ==========================================================
    // types
    typedef struct packed {
        logic       wr;
        logic       use_pointer;
        logic [7:0] ri;
        logic [7:0] wdata;
    } mxc_req_type;
    typedef struct packed {
        logic        claim;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        data_oe;
        logic        rd_n;
        logic        wr_n;
    } mxc_pins_type;
    typedef enum logic [2:0] {TGT_RAM, TGT_OFF, TGT_FLASH_WR, TGT_ERASE, TGT_REFUSED} mxc_tgt_type;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} mxc_state_type;
endpackage
`default_nettype wire

// ===== hdl/mxc_pin_steer.sv
// port pin steering for the two port groups of the external interface
// assumes the caller holds active for the whole off-chip access
`default_nettype none
module mxc_pin_steer
    import mxc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       active,
    input  wire logic       strobe,
    input  wire logic       wr,
    input  wire logic       portsel,
    input  wire logic [15:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] data_in_lo,
    input  wire logic [7:0] data_in_hi,
    output mxc_pins_type    pins_lo,
    output mxc_pins_type    pins_hi,
    output logic [7:0]      rd_data
);
    mxc_pins_type pin_q [2];

    // ==========================================================
    // one pin register set per port group
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
        logic sel;
        assign sel = active && (portsel == 1'(g));
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                pin_q[g] <= '{claim: 1'b0, addr: 16'h0000, data: 8'h00, data_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
            else
            begin
                pin_q[g].claim   <= sel;
                pin_q[g].addr    <= sel ? addr : 16'h0000;
                pin_q[g].data    <= sel ? wdata : 8'h00;
                pin_q[g].data_oe <= sel && wr;
                pin_q[g].rd_n    <= !(sel && strobe && !wr);
                pin_q[g].wr_n    <= !(sel && strobe && wr);
            end
        end
    end

    assign pins_lo = pin_q[0];
    assign pins_hi = pin_q[1];
    // read data from the group that is in use
    assign rd_data = portsel ? data_in_hi : data_in_lo;
endmodule
`default_nettype wire

// ===== test/mxc_offchip_mem.sv
// off-chip byte memory seen through one port group of the interface
// assumes pin fields are registered by the block and change after ref_clk rises
`default_nettype none
module mxc_offchip_mem
    import mxc_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire mxc_pins_type pins,
    output logic [7:0]        data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // storage, folded so every address line matters
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [7:0] idx;
    assign idx = pins.addr[7:0] ^ pins.addr[15:8];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'ha5;
    end
    // drive only while read strobe is low, else inverse of last so stale data never passes
    always_comb
        data_in = (pins.claim && !pins.rd_n) ? mem[idx] : ~last;
    // capture writes while write strobe is low and data is driven
    always @(posedge ref_clk)
    begin
        if (pins.claim && !pins.rd_n)
            last <= mem[idx];
        if (pins.claim && !pins.wr_n && pins.data_oe)
            mem[idx] <= pins.data;
    end
endmodule
`default_nettype wire

// ===== test/mxc_external_move_ctrl_tb.sv
// self-checking bench for the move target and port claim block
// assumes two off-chip memory models and a combinational on-chip ram stub
`default_nettype none
module mxc_move_ctrl_tb
    import mxc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // stimulus, shadows and scoreboard
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   sfr_addr = 8'h00;
    logic         sfr_wr = 1'b0;
    logic         sfr_rd = 1'b0;
    logic [7:0]   sfr_wdata = 8'h00;
    logic         fwe = 1'b0;
    logic         move_req = 1'b0;
    mxc_req_type  move = '0;
    logic [7:0]   sfr_rdata, move_rdata, ram_wdata, ram_rdata, flash_wdata, data_in_lo, data_in_hi;
    logic         move_done, ram_en, ram_we, flash_wr, flash_erase, flash_refused, flash_scratch_sel;
    logic [11:0]  ram_addr;
    logic [15:0]  flash_addr;
    mxc_pins_type pins_lo, pins_hi;
    logic [7:0]   psc = 8'h00, page = 8'h00, cfg = 8'h03;
    logic [15:0]  dp = 16'h0000;
    logic [31:0]  lfsr = 32'h3d34;
    logic [31:0]  r;
    logic [7:0]   shadow [2][256];
    logic [7:0]   pg [3];
    logic [27:0]  ev = '0;
    logic         ev_wr = 1'b0;
    logic         rd_seen = 1'b0;
    logic [7:0]   sfr_q [$];
    logic [27:0]  mv_q [$];
    int           cyc = 0;
    int           fails = 0;
    int           tests_run = 0;
    // ==========================================================
    // clock, design and far side
    always #10 ref_clk = ~ref_clk;
    mxc_move_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_write_erase_enable(fwe),
        .move_req(move_req), .move(move), .move_done(move_done), .move_rdata(move_rdata),
        .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .flash_wr(flash_wr), .flash_erase(flash_erase),
        .flash_refused(flash_refused), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_scratch_sel(flash_scratch_sel), .pins_lo(pins_lo), .pins_hi(pins_hi),
        .data_in_lo(data_in_lo), .data_in_hi(data_in_hi));
    mxc_offchip_mem mem_lo (.ref_clk(ref_clk), .pins(pins_lo), .data_in(data_in_lo));
    mxc_offchip_mem mem_hi (.ref_clk(ref_clk), .pins(pins_hi), .data_in(data_in_hi));
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] ramval(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h9};
    endfunction
    // on-chip ram stub answers in the cycle of the enable
    assign ram_rdata = ramval(ram_addr);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        case (a)
            MXC_PSC_ADDR: psc = d & 8'h07;
            MXC_DPS_ADDR: page = d;
            MXC_CFG_ADDR: cfg = d & 8'h3f;
            MXC_PTRL_ADDR: dp[7:0] = d;
            MXC_PTRH_ADDR: dp[15:8] = d;
            default: ;
        endcase
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
        sfr_q.push_back(e);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
    endtask
    task automatic set_dp(input logic [15:0] v);
        sfr_write(MXC_PTRH_ADDR, v[15:8]);
        sfr_write(MXC_PTRL_ADDR, v[7:0]);
    endtask
    task automatic ext_move(input logic wr, input logic use_dp, input logic [7:0] ri, input logic [7:0] wd);
        logic [15:0] ea;
        logic [27:0] e;
        logic        off;
        logic        grp;
        int          n;
        ea = use_dp ? dp : {page, ri};
        grp = cfg[5];
        off = cfg[3:2] == 2'h3 || (cfg[3:2] != 2'h0 && ea >= 16'h1000);
        if (wr && psc[0] && (!fwe || (psc[1] && ea[15:9] == 7'h7f)))
            e = {3'd3, 25'h0};
        else if (wr && psc[0])
            e = psc[1] ? {3'd2, 1'b0, ea, 8'h00} : {3'd1, psc[2], ea, wd};
        else if (!off)
            e = {8'h00, ea[11:0], wr ? wd : ramval(ea[11:0])};
        else
        begin
            e = {2'b10, grp, 1'b0, ea, wr ? wd : shadow[grp][ea[7:0] ^ ea[15:8]]};
            if (wr)
                shadow[grp][ea[7:0] ^ ea[15:8]] = wd;
        end
        mv_q.push_back(e);
        @(negedge ref_clk);
        move_req = 1'b1;
        move = '{wr: wr, use_pointer: use_dp, ri: ri, wdata: wd};
        @(negedge ref_clk);
        move_req = 1'b0;
        n = 0;
        while (move_done !== 1'b1 && n < 12)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("done", n < 12, 1);
        repeat (2) @(negedge ref_clk);
        check("claim_after", {pins_lo.claim, pins_hi.claim}, 0);
    endtask
    task automatic capture(input mxc_pins_type p, input logic g);
        ev[27:8] = {2'b10, g, 1'b0, p.addr};
        if (!p.wr_n)
        begin
            ev[7:0] = p.data;
            ev_wr = 1'b1;
            check("data_oe_wr", p.data_oe, 1);
        end
        if (!p.rd_n)
            check("data_oe", p.data_oe, 0);
    endtask
    // ==========================================================
    // monitor: records each move's effect and compares with the oldest note
    always @(posedge ref_clk)
        rd_seen <= sfr_rd && rst_n;
    always @(negedge ref_clk)
    begin
        if (rd_seen)
            check("sfr_rdata", sfr_rdata, sfr_q.size() ? sfr_q.pop_front() : 8'hxx);
        if (ram_en)
        begin
            ev = {8'h00, ram_addr, ram_we ? ram_wdata : 8'h00};
            ev_wr = ram_we;
        end
        if (flash_wr || flash_erase || flash_refused)
            ev_wr = 1'b1;
        if (flash_wr)
            ev = {3'd1, flash_scratch_sel, flash_addr, flash_wdata};
        if (flash_erase)
            ev = {3'd2, 1'b0, flash_addr, 8'h00};
        if (flash_refused)
            ev = {3'd3, 25'h0};
        if (ram_en || flash_wr || flash_erase || flash_refused)
            check("claim_inside", {pins_lo.claim, pins_hi.claim}, 0);
        if (pins_lo.claim)
            capture(pins_lo, 1'b0);
        if (pins_hi.claim)
            capture(pins_hi, 1'b1);
        if (move_done)
        begin
            if (!ev_wr)
                ev[7:0] = move_rdata;
            check("move", ev, mv_q.size() ? mv_q.pop_front() : 28'hx);
            ev = '0;
            ev_wr = 1'b0;
        end
    end
    // cycle ceiling against a hang
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            final_report();
        end
    end
    // ==========================================================
    // main sequence
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            shadow[0][i] = i[7:0] ^ 8'ha5;
            shadow[1][i] = i[7:0] ^ 8'ha5;
        end
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        // reset values, unused bits and unmapped place
        sfr_read(MXC_PSC_ADDR, 8'h00);
        sfr_read(MXC_DPS_ADDR, 8'h00);
        sfr_read(MXC_CFG_ADDR, 8'h03);
        sfr_read(MXC_PTRL_ADDR, 8'h00);
        sfr_read(MXC_PTRH_ADDR, 8'h00);
        sfr_write(MXC_PSC_ADDR, 8'hff);
        sfr_read(MXC_PSC_ADDR, 8'h07);
        sfr_write(8'h55, 8'hff);
        sfr_read(8'h55, 8'h00);
        sfr_write(MXC_PSC_ADDR, 8'h00);
        ext_move(1'b0, 1'b0, 8'h34, 8'h00);
        // page select at both ends and a random page
        pg[0] = 8'h00;
        pg[1] = 8'hff;
        r = rnd();
        pg[2] = r[7:0];
        foreach (pg[i])
        begin
            sfr_write(MXC_DPS_ADDR, pg[i]);
            sfr_read(MXC_DPS_ADDR, pg[i]);
            r = rnd();
            ext_move(1'b1, 1'b0, r[7:0], r[15:8]);
            ext_move(1'b0, 1'b0, r[23:16], 8'h00);
        end
        // pointer bytes and the 16-bit form
        for (int i = 0; i < 3; i++)
        begin
            r = rnd();
            set_dp(r[15:0]);
            sfr_read(MXC_PTRH_ADDR, r[15:8]);
            sfr_read(MXC_PTRL_ADDR, r[7:0]);
            ext_move(i[0], 1'b1, 8'h00, r[23:16]);
        end
        // flash steering, erase before program, lock page and enable gate
        fwe = 1'b1;
        set_dp(16'h1234);
        sfr_write(MXC_PSC_ADDR, 8'h03);
        ext_move(1'b1, 1'b1, 8'h00, 8'h77);
        sfr_write(MXC_PSC_ADDR, 8'h01);
        ext_move(1'b1, 1'b1, 8'h00, 8'h3c);
        set_dp(16'h0042);
        sfr_write(MXC_PSC_ADDR, 8'h05);
        ext_move(1'b1, 1'b1, 8'h00, 8'hc3);
        sfr_write(MXC_PSC_ADDR, 8'h03);
        set_dp(16'hfe10);
        ext_move(1'b1, 1'b1, 8'h00, 8'h11);
        set_dp(16'hfdff);
        ext_move(1'b1, 1'b1, 8'h00, 8'h11);
        fwe = 1'b0;
        ext_move(1'b1, 1'b1, 8'h00, 8'h22);
        sfr_write(MXC_PSC_ADDR, 8'h01);
        ext_move(1'b1, 1'b1, 8'h00, 8'h33);
        sfr_write(MXC_PSC_ADDR, 8'h00);
        // off-chip on each port group, ports chosen before mode
        for (int g = 0; g < 2; g++)
        begin
            sfr_write(MXC_CFG_ADDR, {2'b00, g[0], 5'h00});
            sfr_write(MXC_CFG_ADDR, {2'b00, g[0], 5'h0c});
            sfr_read(MXC_CFG_ADDR, {2'b00, g[0], 5'h0c});
            r = rnd();
            set_dp(r[15:0]);
            ext_move(1'b1, 1'b1, 8'h00, r[23:16]);
            ext_move(1'b0, 1'b1, 8'h00, 8'h00);
            sfr_write(MXC_CFG_ADDR, {2'b00, g[0], 5'h04});
            set_dp(16'h0fff);
            ext_move(1'b0, 1'b1, 8'h00, 8'h00);
            set_dp(16'h1000);
            ext_move(1'b0, 1'b1, 8'h00, 8'h00);
            sfr_write(MXC_CFG_ADDR, {2'b00, g[0], 5'h08});
            sfr_write(MXC_DPS_ADDR, 8'h12);
            ext_move(1'b1, 1'b0, r[31:24], 8'h5e);
            ext_move(1'b0, 1'b0, r[31:24], 8'h00);
            sfr_write(MXC_DPS_ADDR, 8'h0a);
            ext_move(1'b0, 1'b0, r[31:24], 8'h00);
        end
        check("left", mv_q.size() + sfr_q.size(), 0);
        final_report();
    end
endmodule
`default_nettype wire
